/* inc/hmp_pkg.sv */
// constants, types and behaviour notes of the external mcu host port
// Notes on behaviour
// RULE_01 - both boot pins low: host port disabled, outside accesses ignored
// RULE_02 - mirror window: boot 01 reserved and refused, boot 10/11 reach iram
// RULE_03 - boot 11 opens the mirror for debugging only; boot 10 is normal use
// RULE_04 - mirror window is 768 Kbytes; its target is iram at 0000_0000 whatever the boot mode
// RULE_05 - advance reading on and last 16 bytes read: host error pin asserted
// RULE_06 - page control bit 1 picks sram (0) or page rom (1) reads
// RULE_07 - prefetch and page bits apply to host 0b_ffff down to 00_0000
// RULE_08 - network controller area reachable only in synchronous sram mode
// RULE_09 - upper 52 Kbytes of the peripheral register area are exposed
// RULE_10 - prefetch fetches the whole aligned 16-byte line of a missed word and serves hits from buffer
// RULE_11 - prefetch enable and page select reset to 0
package hmp_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_BUS_CTRL   = 8'h00;
   localparam logic [7:0]  REG_PAGE_CTRL  = 8'h04;
   localparam logic [7:0]  REG_IRQ_STAT   = 8'h08;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h0c;
   localparam logic [7:0]  REG_STATUS     = 8'h10;
   localparam int          PF_EN_BIT      = 0;
   localparam int          PAGE_SEL_BIT   = 1;
   localparam logic        PF_EN_RST      = 1'h0;
   localparam logic        PAGE_SEL_RST   = 1'h0;
   localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;
   localparam int          IRQ_TAIL       = 0;
   localparam int          IRQ_REFUSED    = 1;
   localparam int          STAT_BOOT_LSB  = 0;
   localparam int          STAT_EN_BIT    = 2;
   localparam int          STAT_BUSY_BIT  = 3;
   // ---------------------------------------------------------------
   // host address map (20-bit host space)
   // ---------------------------------------------------------------
   localparam logic [19:0] IRAM_LO        = 20'h0_0000;
   localparam logic [19:0] IRAM_HI        = 20'hb_ffff;
   localparam logic [19:0] IRAM_TAIL_LO   = 20'hb_fff0;
   localparam logic [19:0] NET_LO         = 20'hc_0000;
   localparam logic [19:0] NET_HI         = 20'hd_ffff;
   localparam logic [19:0] PERI_LO        = 20'hf_3000;
   localparam logic [19:0] PERI_HI        = 20'hf_ffff;
   localparam logic [31:0] IRAM_INT_BASE  = 32'h0000_0000;
   localparam logic [31:0] NET_INT_BASE   = 32'h4000_0000;
   localparam logic [31:0] PERI_INT_BASE  = 32'h4001_3000;
   localparam logic [1:0]  BOOT_EXT_MEM   = 2'h0;
   localparam logic [1:0]  BOOT_SFLASH    = 2'h1;
   localparam logic [1:0]  LINE_LAST      = 2'h3;
   localparam int          LINE_WORDS     = 4;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RG_NONE = 2'b00,
      RG_IRAM = 2'b01,
      RG_NET  = 2'b10,
      RG_PERI = 2'b11
   } hmp_region_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MEM  = 2'b01,
      ST_FILL = 2'b10
   } hmp_state_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [19:0] addr;
      logic [31:0] wdata;
   } hmp_host_req_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        page;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hmp_mem_req_t;
   typedef struct packed {
      hmp_region_t region;
      logic        allowed;
      logic        tail;
      logic [31:0] int_addr;
   } hmp_dec_t;
endpackage

/* verilog/hmp_decode.sv */
// host address decoder of the external mcu host port
`timescale 1ns/10ps
module hmp_decode (
   input  wire logic [19:0]      addr_in,
   input  wire logic [1:0]       boot_in,
   input  wire logic             sync_mode_in,
   output hmp_pkg::hmp_dec_t     dec_out
);
   function automatic logic in_span(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
      in_span = (a >= lo) && (a <= hi);
   endfunction

   always_comb begin
      dec_out = '0;
      if (in_span(addr_in, hmp_pkg::IRAM_LO, hmp_pkg::IRAM_HI)) begin // RULE_04
         dec_out.region   = hmp_pkg::RG_IRAM;
         dec_out.allowed  = (boot_in != hmp_pkg::BOOT_SFLASH); // RULE_02
         dec_out.tail     = in_span(addr_in, hmp_pkg::IRAM_TAIL_LO, hmp_pkg::IRAM_HI);
         dec_out.int_addr = hmp_pkg::IRAM_INT_BASE + {12'h000, addr_in};
      end else if (in_span(addr_in, hmp_pkg::NET_LO, hmp_pkg::NET_HI)) begin
         dec_out.region   = hmp_pkg::RG_NET;
         dec_out.allowed  = sync_mode_in; // RULE_08
         dec_out.int_addr = hmp_pkg::NET_INT_BASE + {12'h000, addr_in - hmp_pkg::NET_LO};
      end else if (in_span(addr_in, hmp_pkg::PERI_LO, hmp_pkg::PERI_HI)) begin
         dec_out.region   = hmp_pkg::RG_PERI;
         dec_out.allowed  = 1'b1; // RULE_09
         dec_out.int_addr = hmp_pkg::PERI_INT_BASE + {12'h000, addr_in - hmp_pkg::PERI_LO};
      end
   end
endmodule // hmp_decode

/* verilog/hmp_pfbuf.sv */
// one-line advance reading buffer of the external mcu host port
`timescale 1ns/10ps
module hmp_pfbuf (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        ce_in,
   input  wire logic        inval_in,
   input  wire logic        wr_in,
   input  wire logic [1:0]  wr_idx_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        tag_set_in,
   input  wire logic [15:0] tag_in,
   input  wire logic [19:0] look_addr_in,
   output logic             hit_out,
   output logic [31:0]      data_out
);
   logic [31:0] line_q [hmp_pkg::LINE_WORDS];
   logic [31:0] line_d [hmp_pkg::LINE_WORDS];
   logic [15:0] tag_q;
   logic [15:0] tag_d;
   logic        vld_q;
   logic        vld_d;

   always_comb begin
      line_d = line_q;
      tag_d  = tag_q;
      vld_d  = vld_q;
      if (wr_in) begin
         line_d[wr_idx_in] = wr_data_in;
         vld_d             = 1'b0;
      end
      if (tag_set_in) begin
         tag_d = tag_in;
         vld_d = 1'b1;
      end
      // stale data after a host write is worse than a refill
      if (inval_in) begin
         vld_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         vld_q <= 1'b0;
         tag_q <= 16'h0000;
         for (int i = 0; i < hmp_pkg::LINE_WORDS; i++) begin
            line_q[i] <= 32'h0000_0000;
         end
      end else if (ce_in) begin
         vld_q  <= vld_d;
         tag_q  <= tag_d;
         line_q <= line_d;
      end
   end

   assign hit_out  = vld_q && (tag_q == look_addr_in[19:4]); // RULE_10
   assign data_out = line_q[look_addr_in[3:2]];
endmodule // hmp_pfbuf

/* verilog/hmp_port.sv */
// external mcu host port: decode, read path, advance reading and registers
`timescale 1ns/10ps
module hmp_port (
   input  wire logic                  clock_in,
   input  wire logic                  srst_in,
   input  wire logic                  ce_in,
   input  wire logic                  boot_select_high_in,
   input  wire logic                  boot_select_low_in,
   input  wire logic                  sync_sram_mode_in,
   input  wire hmp_pkg::hmp_host_req_t host_req_in,
   output logic                       host_ack_out,
   output logic [31:0]                host_rdata_out,
   output logic                       host_error_out_n,
   output hmp_pkg::hmp_mem_req_t      mem_req_out,
   input  wire logic                  mem_ack_in,
   input  wire logic [31:0]           mem_rdata_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [31:0]                reg_rdata_out,
   output logic                       irq_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   hmp_pkg::hmp_state_t    state_q, state_d;
   hmp_pkg::hmp_host_req_t hreq_q, hreq_d;
   hmp_pkg::hmp_mem_req_t  mem_q, mem_d;
   hmp_pkg::hmp_dec_t      dec;
   logic [1:0]             boot_q, boot_d;
   logic                   boot_ok_q, boot_ok_d;
   logic                   pf_en_q, pf_en_d;
   logic                   page_sel_q, page_sel_d;
   logic [1:0]             irq_stat_q, irq_stat_d;
   logic [1:0]             irq_mask_q, irq_mask_d;
   logic                   irq_q, irq_d;
   logic                   ack_q, ack_d;
   logic [31:0]            rdata_q, rdata_d;
   logic                   err_n_q, err_n_d;
   logic                   tail_q, tail_d;
   logic [1:0]             idx_q, idx_d;
   logic [31:0]            reg_rdata_q, reg_rdata_d;
   logic [1:0]             ev;
   logic                   port_en;
   logic                   pf_hit;
   logic [31:0]            pf_data;
   logic                   pf_wr;
   logic                   pf_tag_set;
   logic                   pf_inval;

   assign port_en = boot_ok_q && (boot_q != hmp_pkg::BOOT_EXT_MEM); // RULE_01

   // ---------------------------------------------------------------
   // address decode and advance reading buffer
   // ---------------------------------------------------------------
   hmp_decode u_dec (
      .addr_in      (hreq_q.addr),
      .boot_in      (boot_q),
      .sync_mode_in (sync_sram_mode_in),
      .dec_out      (dec)
   );

   hmp_pfbuf u_pf (
      .clk_in       (clock_in),
      .srst_in      (srst_in),
      .ce_in        (ce_in),
      .inval_in     (pf_inval),
      .wr_in        (pf_wr),
      .wr_idx_in    (idx_q),
      .wr_data_in   (mem_rdata_in),
      .tag_set_in   (pf_tag_set),
      .tag_in       (hreq_q.addr[19:4]),
      .look_addr_in (hreq_q.addr),
      .hit_out      (pf_hit),
      .data_out     (pf_data)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d     = state_q;
      hreq_d      = hreq_q;
      mem_d       = mem_q;
      boot_d      = boot_q;
      boot_ok_d   = boot_ok_q;
      pf_en_d     = pf_en_q;
      page_sel_d  = page_sel_q;
      irq_mask_d  = irq_mask_q;
      ack_d       = 1'b0;
      rdata_d     = rdata_q;
      err_n_d     = 1'b1;
      tail_d      = tail_q;
      idx_d       = idx_q;
      reg_rdata_d = 32'h0000_0000;
      ev          = 2'h0;
      pf_wr       = 1'b0;
      pf_tag_set  = 1'b0;
      pf_inval    = 1'b0;

      // boot pins are caught once, in the first cycle after reset release
      if (!boot_ok_q) begin
         boot_d    = {boot_select_high_in, boot_select_low_in};
         boot_ok_d = 1'b1;
      end

      case (state_q)
         hmp_pkg::ST_IDLE: begin
            hreq_d.valid = 1'b0;
            // a latched request is decoded one cycle after it arrives
            if (hreq_q.valid) begin
               tail_d = pf_en_q && !hreq_q.write && (dec.region == hmp_pkg::RG_IRAM) && dec.tail; // RULE_05 RULE_07
               if (!dec.allowed) begin
                  ack_d               = 1'b1; // RULE_02 RULE_08
                  rdata_d             = 32'h0000_0000;
                  ev[hmp_pkg::IRQ_REFUSED] = 1'b1;
               end else if (hreq_q.write) begin
                  pf_inval    = (dec.region == hmp_pkg::RG_IRAM);
                  mem_d.valid = 1'b1;
                  mem_d.write = 1'b1;
                  mem_d.page  = 1'b0;
                  mem_d.addr  = dec.int_addr;
                  mem_d.wdata = hreq_q.wdata;
                  state_d     = hmp_pkg::ST_MEM;
               end else if (pf_en_q && (dec.region == hmp_pkg::RG_IRAM)) begin
                  if (pf_hit) begin
                     ack_d   = 1'b1; // RULE_10
                     rdata_d = pf_data;
                     err_n_d = !tail_d; // RULE_05
                     ev[hmp_pkg::IRQ_TAIL] = tail_d;
                  end else begin
                     idx_d       = 2'h0;
                     mem_d.valid = 1'b1;
                     mem_d.write = 1'b0;
                     mem_d.page  = page_sel_q; // RULE_06
                     mem_d.addr  = {dec.int_addr[31:4], 4'h0};
                     state_d     = hmp_pkg::ST_FILL;
                  end
               end else begin
                  mem_d.valid = 1'b1;
                  mem_d.write = 1'b0;
                  mem_d.page  = page_sel_q && (dec.region == hmp_pkg::RG_IRAM); // RULE_06 RULE_07
                  mem_d.addr  = dec.int_addr;
                  state_d     = hmp_pkg::ST_MEM;
               end
            end else if (host_req_in.valid && port_en) begin // RULE_01 RULE_03
               hreq_d = host_req_in;
            end
         end
         hmp_pkg::ST_MEM: begin
            if (mem_ack_in) begin
               mem_d.valid = 1'b0;
               ack_d       = 1'b1;
               rdata_d     = mem_q.write ? 32'h0000_0000 : mem_rdata_in;
               state_d     = hmp_pkg::ST_IDLE;
            end
         end
         hmp_pkg::ST_FILL: begin
            // whole 16-byte line is read so later words hit the buffer
            if (mem_ack_in) begin
               pf_wr = 1'b1; // RULE_10
               if (idx_q == hreq_q.addr[3:2]) begin
                  rdata_d = mem_rdata_in;
               end
               if (idx_q == hmp_pkg::LINE_LAST) begin
                  pf_tag_set  = 1'b1;
                  mem_d.valid = 1'b0;
                  ack_d       = 1'b1;
                  err_n_d     = !tail_q; // RULE_05
                  ev[hmp_pkg::IRQ_TAIL] = tail_q;
                  state_d     = hmp_pkg::ST_IDLE;
               end else begin
                  idx_d      = idx_q + 2'h1;
                  mem_d.addr = {mem_q.addr[31:4], idx_d, 2'h0};
               end
            end
         end
         default: begin
            state_d = hmp_pkg::ST_IDLE;
         end
      endcase

      // ------------------------------------------------------------
      // register port
      // ------------------------------------------------------------
      irq_stat_d = irq_stat_q;
      if (reg_wr_in) begin
         if (reg_addr_in == hmp_pkg::REG_BUS_CTRL) begin
            pf_en_d = reg_wdata_in[hmp_pkg::PF_EN_BIT];
         end else if (reg_addr_in == hmp_pkg::REG_PAGE_CTRL) begin
            page_sel_d = reg_wdata_in[hmp_pkg::PAGE_SEL_BIT]; // RULE_06
         end else if (reg_addr_in == hmp_pkg::REG_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~reg_wdata_in[1:0];
         end else if (reg_addr_in == hmp_pkg::REG_IRQ_MASK) begin
            irq_mask_d = reg_wdata_in[1:0];
         end
      end
      // a new event beats a clear in the same cycle
      irq_stat_d = irq_stat_d | ev;
      irq_d      = |(irq_stat_d & irq_mask_d);

      if (reg_rd_in) begin
         if (reg_addr_in == hmp_pkg::REG_BUS_CTRL) begin
            reg_rdata_d[hmp_pkg::PF_EN_BIT] = pf_en_q;
         end else if (reg_addr_in == hmp_pkg::REG_PAGE_CTRL) begin
            reg_rdata_d[hmp_pkg::PAGE_SEL_BIT] = page_sel_q;
         end else if (reg_addr_in == hmp_pkg::REG_IRQ_STAT) begin
            reg_rdata_d[1:0] = irq_stat_q;
         end else if (reg_addr_in == hmp_pkg::REG_IRQ_MASK) begin
            reg_rdata_d[1:0] = irq_mask_q;
         end else if (reg_addr_in == hmp_pkg::REG_STATUS) begin
            reg_rdata_d[hmp_pkg::STAT_BOOT_LSB +: 2] = boot_q;
            reg_rdata_d[hmp_pkg::STAT_EN_BIT]        = port_en;
            reg_rdata_d[hmp_pkg::STAT_BUSY_BIT]      = (state_q != hmp_pkg::ST_IDLE);
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_q     <= hmp_pkg::ST_IDLE;
         hreq_q      <= '0;
         mem_q       <= '0;
         boot_q      <= hmp_pkg::BOOT_EXT_MEM;
         boot_ok_q   <= 1'b0;
         pf_en_q     <= hmp_pkg::PF_EN_RST; // RULE_11
         page_sel_q  <= hmp_pkg::PAGE_SEL_RST; // RULE_11
         irq_stat_q  <= 2'h0;
         irq_mask_q  <= hmp_pkg::IRQ_MASK_RST;
         irq_q       <= 1'b0;
         ack_q       <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         err_n_q     <= 1'b1;
         tail_q      <= 1'b0;
         idx_q       <= 2'h0;
         reg_rdata_q <= 32'h0000_0000;
      end else if (ce_in) begin
         state_q     <= state_d;
         hreq_q      <= hreq_d;
         mem_q       <= mem_d;
         boot_q      <= boot_d;
         boot_ok_q   <= boot_ok_d;
         pf_en_q     <= pf_en_d;
         page_sel_q  <= page_sel_d;
         irq_stat_q  <= irq_stat_d;
         irq_mask_q  <= irq_mask_d;
         irq_q       <= irq_d;
         ack_q       <= ack_d;
         rdata_q     <= rdata_d;
         err_n_q     <= err_n_d;
         tail_q      <= tail_d;
         idx_q       <= idx_d;
         reg_rdata_q <= reg_rdata_d;
      end
   end

   assign host_ack_out     = ack_q;
   assign host_rdata_out   = rdata_q;
   assign host_error_out_n = err_n_q;
   assign mem_req_out      = mem_q;
   assign reg_rdata_out    = reg_rdata_q;
   assign irq_out          = irq_q;
endmodule // hmp_port

/* verif/hmp_mem_model.sv */
// memory side model answering the host port's memory requests
`timescale 1ns/10ps
module hmp_mem_model (
   input  wire logic                  clock_in,
   input  wire logic                  srst_in,
   input  wire logic [3:0]            lat_in,
   input  wire hmp_pkg::hmp_mem_req_t mem_req_in,
   output logic                       ack_out,
   output logic [31:0]                rdata_out
);
   // ----
   // answer after lat_in idle cycles
   // ----
   logic [3:0] wait_q;
   // data scrambles the address, so a wrong word shows; stale data inverts
   always_ff @(posedge clock_in) begin
      ack_out <= 1'h0;
      rdata_out <= ~rdata_out;
      wait_q <= 4'h0;
      if (srst_in) begin
         rdata_out <= 32'h0;
      end else if (mem_req_in.valid && !ack_out) begin
         if (wait_q == lat_in) begin
            ack_out <= 1'h1;
            rdata_out <= mem_req_in.addr ^ 32'hc3c3_0000;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule // hmp_mem_model

/* verif/hmp_port_sva.sv */
// assertions of the external mcu host port, bound to its top
`timescale 1ns/10ps
module hmp_port_chk (
   input wire logic                   clock_in,
   input wire logic                   srst_in,
   input wire logic                   ce_in,
   input wire logic                   boot_select_high_in,
   input wire logic                   boot_select_low_in,
   input wire logic                   sync_sram_mode_in,
   input wire hmp_pkg::hmp_host_req_t host_req_in,
   input wire logic                   host_ack_out,
   input wire logic [31:0]            host_rdata_out,
   input wire logic                   host_error_out_n,
   input wire hmp_pkg::hmp_mem_req_t  mem_req_out,
   input wire logic                   mem_ack_in,
   input wire logic [7:0]             reg_addr_in,
   input wire logic [31:0]            reg_wdata_in,
   input wire logic                   reg_wr_in
);
   // ----
   // shadow of control bits and last host request
   // ----
   logic        pf_q;
   logic        pg_q;
   logic        lwr_q;
   logic [19:0] la_q;
   logic        tail;
   logic        mir;
   assign tail = la_q >= hmp_pkg::IRAM_TAIL_LO && la_q <= hmp_pkg::IRAM_HI;
   assign mir = la_q <= hmp_pkg::IRAM_HI;
   // relies on the host never issuing while busy
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pf_q <= 1'h0;
         pg_q <= 1'h0;
         lwr_q <= 1'h0;
         la_q <= 20'h0;
      end else if (ce_in) begin
         if (reg_wr_in && reg_addr_in == hmp_pkg::REG_BUS_CTRL)
            pf_q <= reg_wdata_in[hmp_pkg::PF_EN_BIT];
         if (reg_wr_in && reg_addr_in == hmp_pkg::REG_PAGE_CTRL)
            pg_q <= reg_wdata_in[hmp_pkg::PAGE_SEL_BIT];
         if (host_req_in.valid) begin
            la_q <= host_req_in.addr;
            lwr_q <= host_req_in.write;
         end
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   sequence s_err_ack;
      !host_error_out_n && host_ack_out;
   endsequence
   a_port_off: assert property (!boot_select_high_in && !boot_select_low_in |-> !host_ack_out && !mem_req_out.valid)
      else $error("port answered while disabled");
   a_mirror_refused: assert property (host_ack_out && !boot_select_high_in && mir |-> host_rdata_out == 32'h0)
      else $error("reserved mirror returned data");
   a_mirror_map: assert property (mem_req_out.valid && !lwr_q && mir |-> mem_req_out.addr <= 32'h000b_ffff && mem_req_out.page == pg_q)
      else $error("mirror request misplaced or wrong style");
   a_page_scope: assert property (mem_req_out.valid && !mir |-> !mem_req_out.page)
      else $error("page style outside mirror");
   a_net_sync: assert property (mem_req_out.valid && la_q >= hmp_pkg::NET_LO && la_q <= hmp_pkg::NET_HI |-> sync_sram_mode_in)
      else $error("network area reached without sync mode");
   a_peri_map: assert property (mem_req_out.valid && la_q >= hmp_pkg::PERI_LO |-> mem_req_out.addr == hmp_pkg::PERI_INT_BASE + {12'h0, la_q - hmp_pkg::PERI_LO})
      else $error("peripheral address wrong");
   a_tail_err: assert property (host_ack_out |-> host_error_out_n == !(pf_q && boot_select_high_in && tail && !lwr_q))
      else $error("error pin wrong at answer");
   a_err_pulse: assert property (!host_error_out_n |-> s_err_ack ##1 host_error_out_n)
      else $error("error pin not a pulse with ack");
   a_mem_hold: assert property (mem_req_out.valid && !mem_ack_in |=> mem_req_out.valid && $stable(mem_req_out.addr))
      else $error("memory request dropped early");
   a_fill_step: assert property (mem_ack_in && mem_req_out.valid && pf_q && mir && !lwr_q && mem_req_out.addr[3:2] != 2'h3 |=> mem_req_out.valid && mem_req_out.addr == $past(mem_req_out.addr) + 32'h4)
      else $error("line fill did not step");
endmodule // hmp_port_chk

bind hmp_port hmp_port_chk u_hmp_port_chk (
   .clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in), .boot_select_high_in(boot_select_high_in),
   .boot_select_low_in(boot_select_low_in), .sync_sram_mode_in(sync_sram_mode_in), .host_req_in(host_req_in),
   .host_ack_out(host_ack_out), .host_rdata_out(host_rdata_out), .host_error_out_n(host_error_out_n),
   .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in)
);

/* verif/hmp_port_tb.sv */
// self-checking bench of the external mcu host port
`timescale 1ns/10ps
module hmp_port_tb;
   logic                   clock_in, srst_in, boot_hi, boot_lo, sync_mode, ack, err_n;
   logic                   irq, mem_ack, reg_wr, reg_rd, e, mpage;
   hmp_pkg::hmp_host_req_t host_req;
   hmp_pkg::hmp_mem_req_t  mem_req;
   logic [3:0]             lat;
   logic [7:0]             reg_addr;
   logic [31:0]            rdata, mem_rdata, reg_wdata, reg_rdata, maddr, d;
   int                     err_total, checks, cyc, mcnt, n;
   hmp_port u_hmp_port (
      .clock_in(clock_in), .srst_in(srst_in), .ce_in(1'h1), .boot_select_high_in(boot_hi),
      .boot_select_low_in(boot_lo), .sync_sram_mode_in(sync_mode), .host_req_in(host_req), .host_ack_out(ack),
      .host_rdata_out(rdata), .host_error_out_n(err_n), .mem_req_out(mem_req), .mem_ack_in(mem_ack),
      .mem_rdata_in(mem_rdata), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq));
   hmp_mem_model u_hmp_mem_model (
      .clock_in(clock_in), .srst_in(srst_in), .lat_in(lat), .mem_req_in(mem_req), .ack_out(mem_ack),
      .rdata_out(mem_rdata));
   // ----
   // clock, memory monitor, hang limit
   // ----
   initial begin
      clock_in = 1'h0;
      forever #50 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc++;
      if (mem_ack === 1'h1) begin
         if (mcnt == 0) begin
            maddr = mem_req.addr;
            mpage = mem_req.page;
         end
         mcnt++;
      end
      if (cyc == 6000) begin
         err_total++;
         wrap_up;
      end
   end
   // ----
   // shared tasks
   // ----
   function automatic logic [31:0] mdat(input logic [31:0] a);
      return a ^ 32'hc3c3_0000;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_total == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // boot pins are caught once after release, so each mode needs a reset
   task automatic restart(input logic [1:0] b, input logic s);
      @(posedge clock_in);
      srst_in <= 1'h1;
      {boot_hi, boot_lo} <= b;
      sync_mode <= s;
      repeat (6) @(posedge clock_in);
      srst_in <= 1'h0;
      repeat (2) @(posedge clock_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clock_in);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clock_in);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task automatic hrd(input logic [19:0] a);
      mcnt = 0;
      @(posedge clock_in);
      host_req <= '{valid: 1'h1, write: 1'h0, addr: a, wdata: 32'h0};
      @(posedge clock_in);
      host_req.valid <= 1'h0;
      n = 0;
      #1;
      while (ack !== 1'h1 && n < 40) begin
         @(posedge clock_in);
         #1 n++;
      end
      d = rdata;
      e = err_n;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_off;
      restart(2'h0, 1'h0);
      hrd(20'h0_0100);
      chk(32'(n), 32'd40);
      chk(32'(mcnt), 32'd0);
      rd(hmp_pkg::REG_STATUS);
      chk(d, 32'h0);
   endtask
   task automatic t_refuse;
      restart(2'h1, 1'h0);
      rd(hmp_pkg::REG_STATUS);
      chk(d, 32'h5);
      hrd(20'h0_1000);
      chk(d, 32'h0);
      chk(32'(mcnt), 32'd0);
      chk(32'(n), 32'd1);
      hrd(20'hc_0000);
      chk(32'(mcnt), 32'd0);
      rd(hmp_pkg::REG_IRQ_STAT);
      chk(d, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(hmp_pkg::REG_IRQ_MASK, 32'h2);
      @(posedge clock_in);
      #1 chk({31'h0, irq}, 32'h1);
      wr(hmp_pkg::REG_IRQ_STAT, 32'h2);
      @(posedge clock_in);
      #1 chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_plain;
      restart(2'h2, 1'h1);
      lat <= 4'h2;
      rd(hmp_pkg::REG_BUS_CTRL);
      chk(d, 32'h0);
      rd(hmp_pkg::REG_PAGE_CTRL);
      chk(d, 32'h0);
      rd(8'h20);
      chk(d, 32'h0);
      hrd(20'h0_1230);
      chk(d, mdat(32'h1230));
      chk({31'h0, mpage}, 32'h0);
      wr(hmp_pkg::REG_PAGE_CTRL, 32'h2);
      hrd(20'hb_fffc);
      chk(d, mdat(32'h000b_fffc));
      chk({31'h0, mpage}, 32'h1);
      chk({31'h0, e}, 32'h1);
      hrd(20'hc_0010);
      chk(d, mdat(32'h4000_0010));
      chk({31'h0, mpage}, 32'h0);
      hrd(20'hf_3004);
      chk(maddr, 32'h4001_3004);
      hrd(20'hf_2ffc);
      chk(32'(mcnt), 32'd0);
   endtask
   task automatic t_pf;
      lat <= 4'h0;
      wr(hmp_pkg::REG_BUS_CTRL, 32'h1);
      hrd(20'h0_2008);
      chk(32'(mcnt), 32'd4);
      chk(maddr, 32'h2000);
      chk(d, mdat(32'h2008));
      hrd(20'h0_200c);
      chk(32'(n), 32'd1);
      chk(32'(mcnt), 32'd0);
      chk(d, mdat(32'h200c));
      hrd(20'hf_3010);
      chk(32'(mcnt), 32'd1);
      hrd(20'hb_fff4);
      chk({31'h0, e}, 32'h0);
      hrd(20'hb_ffe8);
      chk({31'h0, e}, 32'h1);
      rd(hmp_pkg::REG_IRQ_STAT);
      chk(d, 32'h3);
   endtask
   task automatic t_dbg;
      restart(2'h3, 1'h0);
      hrd(20'h0_0040);
      chk(d, mdat(32'h40));
      hrd(20'hc_0000);
      chk(d, 32'h0);
   endtask
   initial begin
      srst_in = 1'h1;
      {boot_hi, boot_lo, sync_mode} = 3'h0;
      host_req = '0;
      {reg_wr, reg_rd} = 2'h0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      lat = 4'h1;
      t_off;
      t_refuse;
      t_plain;
      t_pf;
      t_dbg;
      wrap_up;
   end
endmodule // hmp_port_tb
